// ---- hw/dhs_ramp.sv ----
`timescale 1ns/1ns
module dhs_ramp
(
    input wire logic clk,
    input wire logic rst_n,
    dhs_ramp_if.ramp rif
);
    // ------------------------------------------------------------
    // Speed ramp
    // ------------------------------------------------------------
    logic [15:0] diff_up;
    logic [15:0] diff_dn;
    logic [15:0] rate_w;
    logic [16:0] acc_d;
    logic [15:0] acc_q;

    assign diff_up = rif.target - rif.speed;
    assign diff_dn = rif.speed - rif.target;
    assign rate_w  = {8'h00, rif.rate};
    assign acc_d   = {1'b0, acc_q} + {1'b0, rif.speed};

    // Clamp each step so the ramp never overshoots its target
    always_ff @(posedge clk)
    begin
        if (!rst_n || rif.halt)
            rif.speed <= 16'h0000;
        else if (rif.tick && rif.speed < rif.target)
            rif.speed <= rif.speed +
                ((diff_up < rate_w) ? diff_up : rate_w);
        else if (rif.tick && rif.speed > rif.target)
            rif.speed <= rif.speed -
                ((diff_dn < rate_w) ? diff_dn : rate_w);
    end

    // Phase accumulator: one step pulse per carry out
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            acc_q    <= 16'h0000;
            rif.step <= 1'b0;
        end
        else
        begin
            acc_q    <= acc_d[15:0];
            rif.step <= acc_d[16];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rif.at_target <= 1'b1;
        else
            rif.at_target <= (rif.speed == rif.target);
    end
endmodule

// ---- hw/dhs_top.sv ----
`timescale 1ns/1ns
module dhs_top
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        dog_in,
    input  wire logic        zphase_in,
    input  wire logic        inpos_in,
    input  wire logic        zspd_in,
    output logic             step_out,
    output logic             dir_out,
    output logic             irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dhs_ramp_if rif ();
    dhs_pkg::dhs_state_t state_q;

    logic [5:0]  cfg_q;
    logic [15:0] homing_speed_param_q;
    logic [15:0] creep_speed_param_q;
    logic [31:0] accel_q;
    logic [15:0] rev_steps_q;
    logic [15:0] rev_cnt_q;
    logic [15:0] err_code_q;
    logic [1:0]  irq_st_q;
    logic [1:0]  irq_en_q;
    logic [7:0]  tick_cnt_q;
    logic        tick_q;
    logic        dog_q;
    logic        z_q;
    logic        req_q;
    logic        cmp_q;
    logic        stopped_q;
    logic        z_seen_q;
    logic        rev_q;
    logic        fall_seen_q;
    logic        method_q;
    logic        home_dir_q;
    logic        dir_q;
    logic        halt_q;
    logic        done_q;
    logic        e210_q;
    logic        busy;
    logic        wr_en;
    logic        start_req;
    logic        stop_req;
    logic        restart_req;
    logic        e201;
    logic        e209;
    logic        go;
    logic        dog_rise;
    logic        dog_fall;
    logic        z_rise;
    logic        at_zero;
    logic        homing_direction_param;
    logic        homing_method_param;
    logic        homing_retry_param;
    logic [1:0]  homing_accel_select_param;
    logic [31:0] axis_status_word;
    logic [31:0] rd_data;
    logic        rd_err;

    assign homing_direction_param    = cfg_q[dhs_pkg::CFG_DIR];
    assign homing_method_param       = cfg_q[dhs_pkg::CFG_METHOD];
    assign homing_retry_param        = cfg_q[dhs_pkg::CFG_RETRY];
    assign homing_accel_select_param =
        cfg_q[dhs_pkg::CFG_ACC_LO +: 2];

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // Writes land only on the edge that completes the access phase
    assign wr_en = psel && penable && pready && pwrite;
    assign start_req = wr_en && paddr == dhs_pkg::ADDR_CTRL &&
                       pwdata[dhs_pkg::CTRL_START];
    assign stop_req = wr_en && paddr == dhs_pkg::ADDR_CTRL &&
                      pwdata[dhs_pkg::CTRL_STOP];
    assign restart_req = wr_en && paddr == dhs_pkg::ADDR_CTRL &&
                         pwdata[dhs_pkg::CTRL_RESTART];
    assign busy = (state_q != dhs_pkg::DHS_IDLE);
    // A second homing with no retry is refused
    assign e201 = start_req && !busy && cmp_q &&
                  !homing_retry_param;
    assign e209 = restart_req && stopped_q && !busy;
    assign go   = start_req && !busy && !e201;
    assign dog_rise = dog_in && !dog_q;
    assign dog_fall = !dog_in && dog_q;
    assign z_rise   = zphase_in && !z_q;
    assign at_zero  = (rif.speed == 16'h0000);

    // Inputs are synchronous; one stage serves edge detection
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dog_q <= 1'b0;
            z_q   <= 1'b0;
        end
        else
        begin
            dog_q <= dog_in;
            z_q   <= zphase_in;
        end
    end

    // ------------------------------------------------------------
    // Ramp tick divider
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tick_cnt_q <= 8'h00;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_q <= (tick_cnt_q == dhs_pkg::TICK_LAST);
            if (tick_cnt_q == dhs_pkg::TICK_LAST)
                tick_cnt_q <= 8'h00;
            else
                tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Speed command
    // ------------------------------------------------------------
    // Target follows the state; the ramp does the slope
    always_comb
    begin
        rif.tick = tick_q;
        rif.halt = halt_q;
        rif.rate = accel_q[8*homing_accel_select_param +: 8];
        case (state_q)
            dhs_pkg::DHS_HS_RUN,
            dhs_pkg::DHS_REV_MOVE,
            dhs_pkg::DHS_FAST_RUN:
                rif.target = homing_speed_param_q;
            dhs_pkg::DHS_DEC_CREEP,
            dhs_pkg::DHS_CREEP,
            dhs_pkg::DHS_CREEP_Z:
                rif.target = creep_speed_param_q;
            default:
                rif.target = 16'h0000;
        endcase
    end

    dhs_ramp u_ramp
    (
        .clk   (clk),
        .rst_n (rst_n),
        .rif   (rif)
    );

    // ------------------------------------------------------------
    // Homing sequencer
    // ------------------------------------------------------------
    // The stop command overrides every motion state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q     <= dhs_pkg::DHS_IDLE;
            method_q    <= 1'b0;
            home_dir_q  <= 1'b0;
            dir_q       <= 1'b0;
            rev_q       <= 1'b0;
            fall_seen_q <= 1'b0;
            rev_cnt_q   <= 16'h0000;
            halt_q      <= 1'b0;
            done_q      <= 1'b0;
            e210_q      <= 1'b0;
        end
        else
        begin
            halt_q <= 1'b0;
            done_q <= 1'b0;
            e210_q <= 1'b0;
            if (stop_req && busy)
                state_q <= dhs_pkg::DHS_ERR_STOP;
            else
            begin
                case (state_q)
                    dhs_pkg::DHS_IDLE:
                        if (go)
                        begin
                            method_q   <= homing_method_param;
                            home_dir_q <= homing_direction_param;
                            dir_q      <= homing_direction_param;
                            if (dog_in)
                                state_q <= dhs_pkg::DHS_CREEP;
                            else
                                state_q <= dhs_pkg::DHS_HS_RUN;
                        end
                    dhs_pkg::DHS_HS_RUN:
                        if (dog_rise)
                            state_q <= dhs_pkg::DHS_DEC_CREEP;
                    // Dog assumed on; the settled flag lags one cycle
                    dhs_pkg::DHS_DEC_CREEP:
                        if (rif.at_target && rif.speed == rif.target)
                            state_q <= dhs_pkg::DHS_CREEP;
                    dhs_pkg::DHS_CREEP:
                        if (dog_fall)
                        begin
                            rev_q <= !z_seen_q;
                            if (z_seen_q || method_q)
                                state_q <= dhs_pkg::DHS_DOG_STOP;
                            else
                            begin
                                e210_q  <= 1'b1;
                                state_q <= dhs_pkg::DHS_ERR_STOP;
                            end
                        end
                    dhs_pkg::DHS_DOG_STOP:
                        if (at_zero && rev_q)
                        begin
                            dir_q     <= !home_dir_q;
                            rev_cnt_q <= 16'h0000;
                            state_q   <= dhs_pkg::DHS_REV_MOVE;
                        end
                        else if (at_zero)
                            state_q <= dhs_pkg::DHS_CREEP_Z;
                    dhs_pkg::DHS_CREEP_Z:
                        if (z_rise)
                        begin
                            halt_q  <= 1'b1;
                            done_q  <= 1'b1;
                            state_q <= dhs_pkg::DHS_IDLE;
                        end
                    // Step count stands in for one motor turn
                    dhs_pkg::DHS_REV_MOVE:
                        if (rif.step && rev_cnt_q + 16'h0001 >= rev_steps_q)
                        begin
                            halt_q  <= 1'b1;
                            state_q <= dhs_pkg::DHS_REV_WAIT;
                        end
                        else if (rif.step)
                            rev_cnt_q <= rev_cnt_q + 16'h0001;
                    // Settling is left to the amplifier
                    dhs_pkg::DHS_REV_WAIT:
                        if (inpos_in && zspd_in)
                        begin
                            dir_q       <= home_dir_q;
                            fall_seen_q <= 1'b0;
                            state_q     <= dhs_pkg::DHS_FAST_RUN;
                        end
                    // Dog on is ignored here, no creep
                    dhs_pkg::DHS_FAST_RUN:
                    begin
                        if (dog_fall)
                            fall_seen_q <= 1'b1;
                        if (fall_seen_q && z_rise)
                        begin
                            halt_q  <= 1'b1;
                            done_q  <= 1'b1;
                            state_q <= dhs_pkg::DHS_IDLE;
                        end
                    end
                    dhs_pkg::DHS_ERR_STOP:
                        if (at_zero)
                            state_q <= dhs_pkg::DHS_IDLE;
                    default:
                        state_q <= dhs_pkg::DHS_IDLE;
                endcase
            end
        end
    end

    // Marker seen since the start
    always_ff @(posedge clk)
    begin
        if (!rst_n || go)
            z_seen_q <= 1'b0;
        else if (busy && z_rise)
            z_seen_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Request stays set until a homing really completes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            req_q     <= 1'b1;
            cmp_q     <= 1'b0;
            stopped_q <= 1'b0;
        end
        else
        begin
            if (done_q)
            begin
                cmp_q <= 1'b1;
                req_q <= 1'b0;
            end
            else if (go)
            begin
                cmp_q <= 1'b0;
                req_q <= 1'b1;
            end
            if (stop_req && busy)
                stopped_q <= 1'b1;
            else if (go)
                stopped_q <= 1'b0;
        end
    end

    // Error code: a new error beats a software clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            err_code_q <= 16'h0000;
        else if (e201)
            err_code_q <= dhs_pkg::ERR_START_AT_ZERO;
        else if (e209)
            err_code_q <= dhs_pkg::ERR_NO_RESTART;
        else if (e210_q)
            err_code_q <= dhs_pkg::ERR_ZERO_NOT_PASS;
        else if (wr_en && paddr == dhs_pkg::ADDR_ERR)
            err_code_q <= 16'h0000;
    end

    // Sticky interrupt status, set wins over clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_st_q <= 2'b00;
            irq      <= 1'b0;
        end
        else
        begin
            irq_st_q[dhs_pkg::IRQ_DONE] <= done_q ||
                (irq_st_q[dhs_pkg::IRQ_DONE] &&
                 !(wr_en && paddr == dhs_pkg::ADDR_IRQ_CLR &&
                   pwdata[dhs_pkg::IRQ_DONE]));
            irq_st_q[dhs_pkg::IRQ_ERR] <= e201 || e209 || e210_q ||
                (irq_st_q[dhs_pkg::IRQ_ERR] &&
                 !(wr_en && paddr == dhs_pkg::ADDR_IRQ_CLR &&
                   pwdata[dhs_pkg::IRQ_ERR]));
            irq <= |(irq_st_q & irq_en_q);
        end
    end

    // Motion outputs registered at the pins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            step_out <= 1'b0;
            dir_out  <= 1'b0;
        end
        else
        begin
            step_out <= rif.step;
            dir_out  <= dir_q;
        end
    end

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    // Settings take effect at the next start or ramp tick, but rev_steps_q and irq_en_q act at once
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_q                <= 6'h00;
            homing_speed_param_q <= dhs_pkg::RST_HSPD;
            creep_speed_param_q  <= dhs_pkg::RST_CSPD;
            accel_q              <= dhs_pkg::RST_ACCEL;
            rev_steps_q          <= dhs_pkg::RST_REV;
            irq_en_q             <= 2'b00;
        end
        else if (wr_en)
        begin
            case (paddr)
                dhs_pkg::ADDR_CFG:    cfg_q <= pwdata[5:0];
                dhs_pkg::ADDR_HSPD:   homing_speed_param_q <= pwdata[15:0];
                dhs_pkg::ADDR_CSPD:   creep_speed_param_q <= pwdata[15:0];
                dhs_pkg::ADDR_ACCEL:  accel_q <= pwdata;
                dhs_pkg::ADDR_REV:    rev_steps_q <= pwdata[15:0];
                dhs_pkg::ADDR_IRQ_EN: irq_en_q <= pwdata[1:0];
                default:              cfg_q <= cfg_q;
            endcase
        end
    end

    assign axis_status_word = {27'h0000000, cmp_q, req_q,
                               err_code_q != 16'h0000, stopped_q, busy};

    // Read mux; unmapped addresses answer with an error
    always_comb
    begin
        rd_err = 1'b0;
        case (paddr)
            dhs_pkg::ADDR_CTRL:    rd_data = 32'h00000000;
            dhs_pkg::ADDR_CFG:     rd_data = {26'h0000000, cfg_q};
            dhs_pkg::ADDR_HSPD:    rd_data = {16'h0000, homing_speed_param_q};
            dhs_pkg::ADDR_CSPD:    rd_data = {16'h0000, creep_speed_param_q};
            dhs_pkg::ADDR_STAT:    rd_data = axis_status_word;
            dhs_pkg::ADDR_ERR:     rd_data = {16'h0000, err_code_q};
            dhs_pkg::ADDR_IRQ_ST:  rd_data = {30'h00000000, irq_st_q};
            dhs_pkg::ADDR_IRQ_CLR: rd_data = 32'h00000000;
            dhs_pkg::ADDR_IRQ_EN:  rd_data = {30'h00000000, irq_en_q};
            dhs_pkg::ADDR_ACCEL:   rd_data = accel_q;
            dhs_pkg::ADDR_REV:     rd_data = {16'h0000, rev_steps_q};
            default:
            begin
                rd_data = 32'h00000000;
                rd_err  = 1'b1;
            end
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && rd_err;
            if (psel && penable && !pready && !pwrite)
                prdata <= rd_data;
        end
    end
endmodule

// ---- include/dhs_pkg.sv ----
package dhs_pkg;
    // ------------------------------------------------------------
    // Register map, byte addresses on the APB window
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_CFG     = 8'h04;
    localparam logic [7:0] ADDR_HSPD    = 8'h08;
    localparam logic [7:0] ADDR_CSPD    = 8'h0C;
    localparam logic [7:0] ADDR_STAT    = 8'h10;
    localparam logic [7:0] ADDR_ERR     = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_EN  = 8'h20;
    localparam logic [7:0] ADDR_ACCEL   = 8'h24;
    localparam logic [7:0] ADDR_REV     = 8'h28;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_START   = 0;
    localparam int CTRL_STOP    = 1;
    localparam int CTRL_RESTART = 2;
    localparam int CFG_DIR      = 0;
    localparam int CFG_METHOD   = 1;
    localparam int CFG_RETRY    = 2;
    localparam int CFG_ACC_LO   = 4;
    localparam int ST_BUSY      = 0;
    localparam int ST_STOPPED   = 1;
    localparam int ST_ERROR     = 2;
    localparam int ST_REQUEST   = 3;
    localparam int ST_COMPLETE  = 4;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_ERR      = 1;
    // ------------------------------------------------------------
    // Error codes and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ERR_START_AT_ZERO = 16'd201;
    localparam logic [15:0] ERR_NO_RESTART    = 16'd209;
    localparam logic [15:0] ERR_ZERO_NOT_PASS = 16'd210;
    localparam logic [15:0] RST_HSPD  = 16'h1000;
    localparam logic [15:0] RST_CSPD  = 16'h0100;
    localparam logic [31:0] RST_ACCEL = 32'h08040201;
    localparam logic [15:0] RST_REV   = 16'h1000;
    // ------------------------------------------------------------
    // Ramp update tick
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 125;
    localparam int RAMP_TICK_US = 1;
    localparam int RAMP_TICK_CYC = RAMP_TICK_US * CLK_MHZ;
    localparam logic [7:0] TICK_LAST = 8'(RAMP_TICK_CYC - 1);
    // Gray codes along the usual path
    typedef enum logic [3:0] {
        DHS_IDLE      = 4'h0,
        DHS_HS_RUN    = 4'h1,
        DHS_DEC_CREEP = 4'h3,
        DHS_CREEP     = 4'h2,
        DHS_DOG_STOP  = 4'h6,
        DHS_CREEP_Z   = 4'h7,
        DHS_REV_MOVE  = 4'h5,
        DHS_REV_WAIT  = 4'h4,
        DHS_FAST_RUN  = 4'hC,
        DHS_ERR_STOP  = 4'hD
    } dhs_state_t;
endpackage

// ---- include/dhs_ramp_if.sv ----
`timescale 1ns/1ns
// Speed command path between sequencer and ramp generator
interface dhs_ramp_if;
    logic        tick;
    logic        halt;
    logic [15:0] target;
    logic [7:0]  rate;
    logic [15:0] speed;
    logic        step;
    logic        at_target;
    modport ctrl (output tick, halt, target, rate,
                  input speed, step, at_target);
    modport ramp (input tick, halt, target, rate,
                  output speed, step, at_target);
endinterface

// ---- tb/dhs_amp_model.sv ----
`timescale 1ns/1ns
// Axis, dog and amplifier; reset puts the axis back at its start point
module dhs_amp_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mk_en,
    input wire logic step_out,
    input wire logic dir_out,
    output logic     dog_in,
    output logic     zphase_in,
    output logic     inpos_in,
    output logic     zspd_in
);
    int         pos_q;
    int         nxt;
    logic [9:0] idle_q;
    assign nxt = dir_out ? pos_q - 1 : pos_q + 1;
    // Wide window keeps the dog on through the slowdown
    assign dog_in = pos_q >= 100 && pos_q < 200;
    // Settled after 512 quiet cycles, longer than any step gap
    assign inpos_in = idle_q[9];
    assign zspd_in = idle_q[9];
    // One marker pulse per 64-step turn
    always_ff @(posedge clk)
    begin
        zphase_in <= rst_n && step_out && mk_en && nxt % 64 == 0;
        idle_q <= (!rst_n || step_out) ? 10'h000 :
                  idle_q + {9'h000, !idle_q[9]};
        if (!rst_n)
            pos_q <= 0;
        else if (step_out)
            pos_q <= nxt;
    end
endmodule

// ---- tb/dhs_top_props.sv ----
`timescale 1ns/1ns
module dhs_top_props
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        step_out,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Completed APB transfer, and a write to one address
    sequence s_acc;
        psel && penable && pready;
    endsequence
    sequence s_wr(a);
        s_acc ##0 pwrite && paddr == a;
    endsequence
    property p_rdy_pulse; pready |=> !pready; endproperty
    property p_rdy_soon; psel && penable && !pready |-> ##[1:2] pready;
    endproperty
    property p_err_rdy; pslverr |-> pready; endproperty
    property p_unmap; s_acc ##0 paddr > 8'h28 |-> pslverr; endproperty
    property p_ctrl_rd0; s_acc ##0 !pwrite && paddr == 8'h00 |-> !prdata;
    endproperty
    // Speed stays below half a step a cycle, so steps never touch
    property p_step_gap; step_out |=> !step_out; endproperty
    property p_irq_clr; s_wr(8'h1C) ##0 pwdata[1:0] == 2'h3 |-> ##[1:3] !irq;
    endproperty
    property p_irq_mask; s_wr(8'h20) ##0 !pwdata[1:0] |-> ##[1:3] !irq;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready long");
    a_rdy_soon: assert property (p_rdy_soon) else $error("pready late");
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
    a_unmap: assert property (p_unmap) else $error("no pslverr");
    a_ctrl_rd0: assert property (p_ctrl_rd0) else $error("ctrl read");
    a_step_gap: assert property (p_step_gap) else $error("step pair");
    a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
    a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");
endmodule
bind dhs_top dhs_top_props u_dhs_top_props (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .step_out, .irq);

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, mk_en;
    logic        dog_in, zphase_in, inpos_in, zspd_in, step_out, dir_out, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [31:0] exp_q[$];
    int          err_total, n_tests, i, g;
    dhs_top u_dhs_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .dog_in, .zphase_in,
        .inpos_in, .zspd_in, .step_out, .dir_out, .irq);
    dhs_amp_model u_dhs_amp_model (.clk, .rst_n, .mk_en, .step_out,
        .dir_out, .dog_in, .zphase_in, .inpos_in, .zspd_in);
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Bounded wait; a hang ends the run as a failure
    task automatic hang_check(input int n);
        if (n >= 40000)
        begin
            err_total++;
            print_verdict();
        end
    endtask
    // One APB transfer; a read notes d as the word it expects
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        if (!wr)
            exp_q.push_back(d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 40000 && pready !== 1'b1; n++)
            @(posedge clk);
        hang_check(n);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Read data are taken at the edge that samples pready
    always @(posedge clk)
        if (psel && penable && pready && !pwrite)
            check(prdata, exp_q.pop_front());
    task automatic wait_irq();
        int n;
        for (n = 0; n < 40000 && irq !== 1'b1; n++)
            @(posedge clk);
        hang_check(n);
    endtask
    // Reset, then fast ramp, low speeds and a 64-step turn for short runs
    task automatic restart_axis(input logic mk, input logic [5:0] c);
        rst_n <= 1'b0;
        mk_en <= mk;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b1, dhs_pkg::ADDR_ACCEL, 32'h080402FF);
        apb(1'b1, dhs_pkg::ADDR_HSPD, 32'h0800);
        apb(1'b1, dhs_pkg::ADDR_CSPD, 32'h0200);
        apb(1'b1, dhs_pkg::ADDR_CFG, {26'h0, c});
        apb(1'b1, dhs_pkg::ADDR_REV, 32'h40);
        apb(1'b1, dhs_pkg::ADDR_IRQ_EN, 32'h3);
        apb(1'b1, dhs_pkg::ADDR_CTRL, 32'h1);
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, mk_en, rst_n} = '0;
        err_total = 0;
        n_tests = 0;
        r = $urandom(32'hC6BB);
        r = $urandom;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, dhs_pkg::ADDR_STAT, 32'h08);
        apb(1'b0, dhs_pkg::ADDR_ACCEL, dhs_pkg::RST_ACCEL);
        apb(1'b0, 8'h40, 32'h0);
        apb(1'b1, dhs_pkg::ADDR_REV, {16'h0, r[15:0]});
        apb(1'b0, dhs_pkg::ADDR_REV, {16'h0, r[15:0]});
        apb(1'b0, dhs_pkg::ADDR_CTRL, 32'h0);
        restart_axis(1'b1, 6'h02);
        wait_irq();
        apb(1'b0, dhs_pkg::ADDR_STAT, 32'h10);
        apb(1'b0, dhs_pkg::ADDR_IRQ_ST, 32'h1);
        apb(1'b1, dhs_pkg::ADDR_IRQ_CLR, 32'h3);
        apb(1'b1, dhs_pkg::ADDR_CTRL, 32'h1);
        wait_irq();
        apb(1'b0, dhs_pkg::ADDR_ERR, 32'd201);
        restart_axis(1'b0, 6'h00);
        wait_irq();
        apb(1'b0, dhs_pkg::ADDR_ERR, 32'd210);
        // Second method, markers only once the reverse turn has begun
        restart_axis(1'b0, 6'h02);
        for (i = 0; i < 40000 && dir_out !== 1'b1; i++)
            @(posedge clk);
        hang_check(i);
        mk_en <= 1'b1;
        wait_irq();
        apb(1'b0, dhs_pkg::ADDR_STAT, 32'h10);
        check(dir_out, 32'h0);
        // Stop inside the dog, refused restart, then a start there
        restart_axis(1'b1, 6'h00);
        for (i = 0; i < 40000 && dog_in !== 1'b1; i++)
            @(posedge clk);
        hang_check(i);
        apb(1'b1, dhs_pkg::ADDR_CTRL, 32'h2);
        repeat (3000) @(posedge clk);
        apb(1'b1, dhs_pkg::ADDR_CTRL, 32'h4);
        wait_irq();
        apb(1'b0, dhs_pkg::ADDR_ERR, 32'd209);
        apb(1'b1, dhs_pkg::ADDR_CTRL, 32'h1);
        repeat (1000) @(posedge clk);
        // Creep speed 0x200 gives one step every 128 cycles
        for (i = 0; i < 40000 && step_out !== 1'b1; i++)
            @(posedge clk);
        @(posedge clk);
        for (g = 1; g < 200 && step_out !== 1'b1; g++)
            @(posedge clk);
        check(g, 32'd128);
        apb(1'b1, dhs_pkg::ADDR_IRQ_EN, 32'h0);
        repeat (4) @(posedge clk);
        print_verdict();
    end
endmodule
